// ---- src/fsp_pkg.sv ----
// Purpose: Constants for the flash self-program sequencer
// Assumes: 8 KB flash, 32-word pages, 20 MHz system clock
// Notes: Register map is on APB, one register per 32-bit word
package fsp_pkg;
  localparam int PC_MSB = 11;
  localparam int PAGE_MSB = 4;
  localparam int PTR_TOP = PC_MSB + 1;
  localparam int PTR_WORD_TOP = PAGE_MSB + 1;
  localparam int WORD_BITS = PAGE_MSB + 1;
  localparam int PAGE_BITS = PC_MSB - PAGE_MSB;
  localparam int BUF_DEPTH = 1 << WORD_BITS;
  localparam int WINDOW_CYC = 4;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_PTR = 12'h004;
  localparam logic [11:0] OFF_DATA = 12'h008;
  localparam logic [11:0] OFF_ISSUE = 12'h00C;
  localparam logic [11:0] OFF_STATUS = 12'h010;
  localparam logic [11:0] OFF_RDATA = 12'h014;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_LOAD = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam int BIT_EN = 0;
  localparam int BIT_ERS = 1;
  localparam int BIT_WRT = 2;
  localparam int BIT_CLR = 4;
  localparam int ISSUE_STORE = 0;
  localparam int ISSUE_LOAD = 1;
  localparam int ST_HALT = 0;
  localparam int ST_EEBUSY = 1;
  localparam int ST_WINDOW = 2;
  localparam real PROG_TIME_US = 4500.0;
  localparam real CLK_MHZ = 20.0;
  localparam int PROG_CYC = int'(PROG_TIME_US * CLK_MHZ);
  typedef enum logic [1:0] {FSP_IDLE, FSP_ERASE, FSP_WRITE} fsp_state_t;
endpackage : fsp_pkg

// ---- src/fsp_page_buf.sv ----
// Purpose: Temporary page buffer with per-word valid flags
// Assumes: Single clock, synchronous clear of all entries
// Notes: Read data registered; cleared words read as all ones
`timescale 1ns/1ps
module fsp_page_buf #(
  parameter int AW = 5,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata_q
);
  logic [DW-1:0] mem [1<<AW];
  logic [(1<<AW)-1:0] vld_q;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Clear only drops valid flags, so a clear needs one cycle
  always_ff @(posedge clk) begin
    if (clr) begin
      vld_q <= '0;
    end else if (we) begin
      vld_q[waddr] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= vld_q[raddr] ? mem[raddr] : '1;
  end
endmodule : fsp_page_buf

// ---- src/fsp_sequencer.sv ----
// Purpose: Flash self-programming sequencer with APB register access
// Assumes: CPU issues store/load-program events as APB writes to ISSUE
// Notes: Flash array is a port-level model interface (erase/write strobes)
//
// Operation
// - Code 00000011 then store within four cycles erases four pages.
// - Erase ignores data pair, low two page bits and non-page pointer bits.
// - Code 00000001 then store loads data pair into buffer word.
// - Code 00000101 then store writes buffer into addressed page.
// - CPU is stalled for the whole page write.
// - CPU is stalled for the whole four-page erase.
// - Buffer cleared after page write, on clear bit, and on reset.
// - EEPROM write during buffer loading discards loaded data.
// - Buffer words load in any order.
// - Store disabled unless self-program fuse is zero.
// - Store addressing ignores pointer bit 0 and bits above top bit.
// - Load-program reads bytewise, pointer bit 0 picks byte.
// - Target address latched at operation start.
// - EEPROM write blocks flash programming, not load-program reads.
// - Reset during flash write lets the write complete.
// - Enable bit clears on completion or after four idle cycles.
// - Page write bit clears on completion or four-cycle timeout.
// - Clear bit during buffer fill empties the buffer.
`timescale 1ns/1ps
module fsp_sequencer
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SELF_PROGRAM_FUSE_N,
  input wire logic EEPROM_WRITE_BUSY,
  output logic CPU_HALT,
  output logic FLASH_ERASE,
  output logic FLASH_WRITE,
  output logic [PAGE_BITS-1:0] FLASH_PAGE,
  output logic FLASH_BUF_RD,
  output logic [WORD_BITS-1:0] FLASH_BUF_ADDR,
  output logic [15:0] FLASH_BUF_DATA,
  input wire logic [15:0] FLASH_RDATA,
  output logic [PC_MSB:0] FLASH_RADDR
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  fsp_state_t state_q, state_d;
  logic [7:0] ctrl_q;
  logic [2:0] win_q;
  logic [15:0] ptr_q;
  logic [15:0] data_q;
  logic [CNT_W-1:0] cnt_q;
  logic [PAGE_BITS-1:0] page_q;
  logic [7:0] rbyte_q;
  logic fuse_s1_q, fuse_q, eeb_s1_q, eeb_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic loading_q;
  logic [15:0] buf_rdata;

  wire acc = PSEL && PENABLE && !pready_q;
  wire wr = acc && PWRITE;
  wire rd = acc && !PWRITE;
  wire hit_ctrl = PADDR == OFF_CTRL;
  wire hit_ptr = PADDR == OFF_PTR;
  wire hit_data = PADDR == OFF_DATA;
  wire hit_issue = PADDR == OFF_ISSUE;
  wire hit_stat = PADDR == OFF_STATUS;
  wire hit_rdat = PADDR == OFF_RDATA;
  wire mapped = hit_ctrl | hit_ptr | hit_data | hit_issue | hit_stat | hit_rdat;
  wire busy = state_q != FSP_IDLE;
  wire spm_ok = !fuse_q && !eeb_q;
  wire ctrl_wr = wr && hit_ctrl && !busy && spm_ok;
  wire window_open = win_q != 3'd0 && ctrl_q[BIT_EN];
  wire store_ev = wr && hit_issue && PWDATA[ISSUE_STORE] && window_open && spm_ok;
  wire load_ev = wr && hit_issue && PWDATA[ISSUE_LOAD];
  wire go_erase = store_ev && ctrl_q == CMD_ERASE;
  wire go_load = store_ev && ctrl_q == CMD_LOAD;
  wire go_write = store_ev && ctrl_q == CMD_WRITE;
  wire [PC_MSB:0] z_word = ptr_q[PTR_TOP:1];
  // Four pages share one erase block, so low page bits drop
  wire [PAGE_BITS-1:0] erase_page = {z_word[PC_MSB:PAGE_MSB+3], 2'b00};
  wire [PAGE_BITS-1:0] write_page = z_word[PC_MSB:PAGE_MSB+1];
  wire [WORD_BITS-1:0] load_word = z_word[PAGE_MSB:0];
  wire op_done = busy && cnt_q == CNT_W'(1);
  wire clr_ev = ctrl_wr && PWDATA[BIT_CLR];
  wire eeb_drop = eeb_q && loading_q;
  // Reset spares the buffer while a running write still reads it
  wire rst_clr = SRST && state_q != FSP_WRITE;
  wire buf_clr = rst_clr || clr_ev || (op_done && state_q == FSP_WRITE) || eeb_drop;

  always_ff @(posedge CLK) begin
    fuse_s1_q <= SELF_PROGRAM_FUSE_N;
    fuse_q <= fuse_s1_q;
    eeb_s1_q <= EEPROM_WRITE_BUSY;
    eeb_q <= eeb_s1_q;
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FSP_IDLE: begin
        if (go_erase) begin
          state_d = FSP_ERASE;
        end else if (go_write) begin
          state_d = FSP_WRITE;
        end
      end
      FSP_ERASE, FSP_WRITE: begin
        if (op_done) begin
          state_d = FSP_IDLE;
        end
      end
      default: state_d = FSP_IDLE;
    endcase
  end

  // Reset does not abort a running erase or write
  always_ff @(posedge CLK) begin
    if (SRST && !busy) begin
      state_q <= FSP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (go_erase || go_write) begin
      cnt_q <= CNT_W'(PROG_CYCLES);
      page_q <= go_erase ? erase_page : write_page;
    end else if (busy) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  // Window counts from the cycle after the control write
  always_ff @(posedge CLK) begin
    if (SRST && !busy) begin
      ctrl_q <= 8'h00;
      win_q <= 3'd0;
    end else if (ctrl_wr) begin
      // Top two code bits dropped, so stray bits 7:6 can alias a command
      ctrl_q <= {2'b00, PWDATA[5:0]};
      win_q <= 3'(WINDOW_CYC);
    end else if (op_done) begin
      ctrl_q <= 8'h00;
      win_q <= 3'd0;
    end else if (store_ev && !go_erase && !go_write) begin
      ctrl_q <= 8'h00;
      win_q <= 3'd0;
    end else if (!busy && win_q != 3'd0) begin
      win_q <= win_q - 3'd1;
      if (win_q == 3'd1) begin
        ctrl_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      ptr_q <= 16'h0000;
      data_q <= 16'h0000;
      loading_q <= 1'b0;
      rbyte_q <= 8'h00;
    end else begin
      if (wr && hit_ptr) begin
        ptr_q <= PWDATA[15:0];
      end
      if (wr && hit_data) begin
        data_q <= PWDATA[15:0];
      end
      if (buf_clr || go_write) begin
        loading_q <= 1'b0;
      end else if (go_load) begin
        loading_q <= 1'b1;
      end
      if (load_ev) begin
        rbyte_q <= ptr_q[0] ? FLASH_RDATA[15:8] : FLASH_RDATA[7:0];
      end
    end
  end

  fsp_page_buf #(
    .AW(WORD_BITS),
    .DW(16)
  ) u_buf (
    .clk(CLK),
    .clr(buf_clr),
    .we(go_load && !buf_clr),
    .waddr(load_word),
    .wdata(data_q),
    .raddr(FLASH_BUF_ADDR),
    .rdata_q(buf_rdata)
  );

  wire [31:0] rd_mux =
    hit_ctrl ? {24'h0, ctrl_q} :
    hit_ptr ? {16'h0, ptr_q} :
    hit_data ? {16'h0, data_q} :
    hit_stat ? {29'h0, window_open, eeb_q, busy} :
    hit_rdat ? {24'h0, rbyte_q} : 32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      pready_q <= acc;
      prdata_q <= rd ? rd_mux : 32'h0000_0000;
      PSLVERR <= acc && !mapped;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST && !busy) begin
      CPU_HALT <= 1'b0;
      FLASH_ERASE <= 1'b0;
      FLASH_WRITE <= 1'b0;
      FLASH_PAGE <= '0;
      FLASH_BUF_RD <= 1'b0;
      FLASH_BUF_ADDR <= '0;
    end else begin
      CPU_HALT <= state_d != FSP_IDLE;
      FLASH_ERASE <= state_d == FSP_ERASE;
      FLASH_WRITE <= state_d == FSP_WRITE;
      FLASH_PAGE <= (go_erase || go_write) ? state_d == FSP_ERASE ? erase_page : write_page
                                           : page_q;
      FLASH_BUF_RD <= state_d == FSP_WRITE;
      FLASH_BUF_ADDR <= (state_q == FSP_WRITE) ? FLASH_BUF_ADDR + WORD_BITS'(1) : '0;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign FLASH_BUF_DATA = buf_rdata;
  assign FLASH_RADDR = ptr_q[PTR_TOP:1];
endmodule : fsp_sequencer

// ---- tb/fsp_checker.sv ----
// Purpose: Port properties of the sequencer
// Assumes: One clock, sync reset
// Notes: Op length kept by a helper counter
`timescale 1ns/1ps
module fsp_checker
  import fsp_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SELF_PROGRAM_FUSE_N,
  input wire logic CPU_HALT,
  input wire logic FLASH_ERASE,
  input wire logic FLASH_WRITE,
  input wire logic [PAGE_BITS-1:0] FLASH_PAGE
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SRST);
  logic busy;
  int len_q;
  assign busy = FLASH_ERASE | FLASH_WRITE;
  // Not cleared by reset, an op outlives it
  always_ff @(posedge CLK) begin
    len_q <= busy ? len_q + 1 : 0;
  end
  AST_READY_WAIT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
    else $error("lone error");
  AST_HALT_ERASE: assert property (FLASH_ERASE |-> CPU_HALT)
    else $error("erase without halt");
  AST_HALT_WRITE: assert property (FLASH_WRITE |-> CPU_HALT)
    else $error("write without halt");
  AST_ERASE_BLOCK: assert property (FLASH_ERASE |-> FLASH_PAGE[1:0] == 2'h0)
    else $error("erase block misaligned");
  AST_PAGE_HELD: assert property (busy && $past(busy) |-> $stable(FLASH_PAGE))
    else $error("page moved");
  AST_OP_LENGTH: assert property ($fell(busy) |-> len_q == PROG_CYCLES)
    else $error("op length wrong");
  AST_FUSE_BLOCK: assert property (SELF_PROGRAM_FUSE_N [*8] |=> !$rose(busy))
    else $error("op with fuse off");
  cover property ($rose(FLASH_ERASE));
  cover property ($rose(FLASH_WRITE));
  cover property (PSLVERR);
endmodule : fsp_checker

bind fsp_sequencer fsp_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .CLK, .SRST, .PSEL, .PENABLE, .PREADY, .PSLVERR, .SELF_PROGRAM_FUSE_N,
  .CPU_HALT, .FLASH_ERASE, .FLASH_WRITE, .FLASH_PAGE
);

// ---- tb/fsp_flash_model.sv ----
// Purpose: Flash array stand-in
// Assumes: Read word is a fixed function of address
// Notes: Upper nibble marks every word; page writes captured per word
`timescale 1ns/1ps
module fsp_flash_model
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic [PC_MSB:0] raddr,
  input wire logic buf_rd,
  input wire logic [WORD_BITS-1:0] baddr,
  input wire logic [15:0] bdata,
  output logic [15:0] rdata
);
  logic v_q;
  logic [WORD_BITS-1:0] a_q;
  logic [15:0] got [BUF_DEPTH];
  assign rdata = {4'hA, raddr};
  // Buffer data trails its address by one clock
  always_ff @(posedge clk) begin
    v_q <= buf_rd;
    a_q <= baddr;
    if (buf_rd && !v_q) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        got[i] <= 16'h0000;
      end
    end else if (v_q) begin
      got[a_q] <= bdata;
    end
  end
endmodule : fsp_flash_model

// ---- tb/flash_self_program_sequencer_bench.sv ----
// Purpose: Self-checking bench for the sequencer
// Assumes: Short op time through PROG_CYCLES
// Notes: Buffer words are checked through the flash model's capture
`timescale 1ns/1ps
module flash_self_program_sequencer_bench import fsp_pkg::*;;
  // Long enough for the buffer walk to cover all words
  localparam int PC = 40;
  logic clk = 1'h0, srst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic fuse_n = 1'h0, ee_busy = 1'h0, pready, pslverr, er, halt, ers, wrt;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0001_35A9, prdata, rd, z, dv;
  logic [PAGE_BITS-1:0] page;
  logic [15:0] frdata, buf_data, exp_buf [BUF_DEPTH];
  logic buf_rd;
  logic [WORD_BITS-1:0] buf_addr;
  logic [PC_MSB:0] fraddr;
  logic [4:0] w;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  fsp_sequencer #(.PROG_CYCLES(PC)) DUT (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SELF_PROGRAM_FUSE_N(fuse_n), .EEPROM_WRITE_BUSY(ee_busy), .CPU_HALT(halt),
    .FLASH_ERASE(ers), .FLASH_WRITE(wrt), .FLASH_PAGE(page), .FLASH_BUF_RD(buf_rd),
    .FLASH_BUF_ADDR(buf_addr), .FLASH_BUF_DATA(buf_data), .FLASH_RDATA(frdata),
    .FLASH_RADDR(fraddr)
  );
  fsp_flash_model u_flash (
    .clk(clk), .raddr(fraddr), .buf_rd(buf_rd), .baddr(buf_addr), .bdata(buf_data),
    .rdata(frdata)
  );
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [6:0] exp_page(input logic [7:0] c, input logic [12:0] p);
    return c == CMD_ERASE ? {p[12:8], 2'h0} : p[12:6];
  endfunction : exp_page
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    pen <= 1'h0;
  endtask : apb
  task automatic idle(input int n);
    // Zero keeps psel up for a back-to-back setup
    if (n > 0) psel <= 1'h0;
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic op(input logic [7:0] c, input logic [12:0] p, input int gap,
                    input logic ex, input logic rst);
    int n;
    apb(1'h1, OFF_PTR, {19'h0_0000, p});
    apb(1'h1, OFF_CTRL, {24'h00_0000, c});
    idle(gap);
    apb(1'h1, OFF_ISSUE, 32'h0000_0001);
    apb(1'h1, OFF_PTR, ~{19'h0_0000, p});
    idle(1);
    n = 0;
    while (!(ers | wrt) && n < 8) begin
      @(posedge clk);
      n++;
    end
    chk(ers | wrt, ex);
    if (ex) begin
      chk(page, exp_page(c, p));
      chk(halt, 1'h1);
      if (rst) begin
        srst <= 1'h1;
        @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        chk(ers | wrt, 1'h1);
      end
      while ((ers | wrt) && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk(ers | wrt, 1'h0);
    end
  endtask : op
  // Written page against the words loaded since the last clear
  task automatic chk_page();
    for (int k = 0; k < BUF_DEPTH; k++) begin
      chk(u_flash.got[k], exp_buf[k]);
      exp_buf[k] = 16'hFFFF;
    end
  endtask : chk_page
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    foreach (exp_buf[k]) exp_buf[k] = 16'hFFFF;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    apb(1'h0, 12'h020, 32'h0000_0000);
    chk(er, 1'h1);
    for (int i = 0; i < 6; i++) begin
      z = rnd();
      apb(1'h1, OFF_PTR, z);
      apb(1'h1, OFF_ISSUE, 32'h0000_0002);
      apb(1'h0, OFF_RDATA, 32'h0000_0000);
      idle(1);
      chk(fraddr, z[12:1]);
      chk(rd[7:0], z[0] ? {4'hA, z[12:9]} : z[8:1]);
    end
    z = rnd();
    op(CMD_ERASE, z[12:0], 0, 1'h1, 1'h0);
    w = 5'h03;
    for (int i = 0; i < 4; i++) begin
      dv = rnd();
      exp_buf[w] = dv[15:0];
      apb(1'h1, OFF_DATA, dv);
      op(CMD_LOAD, {z[12:6], w, 1'h0}, 0, 1'h0, 1'h0);
      w = w + 5'h0B;
    end
    op(CMD_WRITE, {z[12:6], 6'h00}, 0, 1'h1, 1'h0);
    chk_page();
    op(CMD_WRITE, {z[12:6], 6'h00}, 2, 1'h0, 1'h0);
    op(8'h07, z[12:0], 0, 1'h0, 1'h0);
    op(8'h23, z[12:0], 0, 1'h0, 1'h0);
    apb(1'h1, OFF_DATA, rnd());
    op(CMD_LOAD, {z[12:6], 6'h0E}, 0, 1'h0, 1'h0);
    op(8'h11, z[12:0], 0, 1'h0, 1'h0);
    op(CMD_WRITE, {z[12:6], 6'h00}, 0, 1'h1, 1'h0);
    chk_page();
    fuse_n <= 1'h1;
    idle(4);
    op(CMD_ERASE, z[12:0], 0, 1'h0, 1'h0);
    fuse_n <= 1'h0;
    apb(1'h1, OFF_DATA, rnd());
    op(CMD_LOAD, {z[12:6], 6'h12}, 0, 1'h0, 1'h0);
    ee_busy <= 1'h1;
    idle(4);
    op(CMD_WRITE, {z[12:6], 6'h00}, 0, 1'h0, 1'h0);
    ee_busy <= 1'h0;
    idle(4);
    op(CMD_WRITE, {z[12:6], 6'h00}, 0, 1'h1, 1'h1);
    chk_page();
    tally_and_finish();
  end
endmodule : flash_self_program_sequencer_bench
